// File: logic/dcp_pkg.sv
// Package with constants and state types for the DDR3 power-state block.
package dcp_pkg;
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned T_POWERUP_US = 500;
  localparam int unsigned POWERUP_CYC = T_POWERUP_US * CLK_MHZ;
  localparam int unsigned T_XS_NS = 170;
  localparam int unsigned XS_CYC = (T_XS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned XPR_MIN_CK = 5;
  localparam int unsigned XPR_CYC =
    (XS_CYC > XPR_MIN_CK) ? XS_CYC : XPR_MIN_CK;
  localparam int unsigned XP_CYC = 3;
  localparam int unsigned CNT_W = 16;
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  localparam logic [2:0] BA_MR3 = 3'h3;
  localparam int unsigned A_DLL_EN = 0;
  localparam int unsigned A_DLL_RST = 8;
  localparam int unsigned A_ZQ_LONG = 10;
  typedef enum logic [3:0] {
    DCP_RESET, DCP_WAKE, DCP_XPR, DCP_MR2, DCP_MR3, DCP_MR1, DCP_MR0,
    DCP_ZQ, DCP_CAL, DCP_IDLE, DCP_ACTIVE, DCP_BUSY, DCP_APD, DCP_PPD,
    DCP_SREF, DCP_EXIT
  } dcp_state_e;
  typedef enum logic [2:0] {
    DCP_CMD_NOP, DCP_CMD_ACT, DCP_CMD_RW, DCP_CMD_PRE, DCP_CMD_REF,
    DCP_CMD_MRS, DCP_CMD_ZQL, DCP_CMD_OTHER
  } dcp_cmd_e;
endpackage

// File: logic/dcp_power_state.sv
// DDR3 CKE power-state tracker and power-up initialization sequencer.
// Behaviour
// - Self-refresh entry only from idle, by REFRESH with CKE falling.
// - CKE fall when busy: precharge power-down if banks closed, else active.
// - Bank active plus CKE falling with NOP enters active power-down.
// - Refreshing or idle, CKE falling with NOP enters precharge power-down.
// - No refresh happens in power-down; controller plans refresh around it.
// - ODT never steers CKE transitions; termination is off in self-refresh.
// - Commands and addresses are ignored in self-refresh and power-down.
// - After reset release wait 500 us before CKE rises; device initializes.
// - Termination stays high-impedance in reset and until CKE is high.
// - Deselect acts exactly as NOP and never ends a burst.
// - Self-refresh exits as soon as CKE returns high.
module dcp_power_state
  import dcp_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = dcp_pkg::POWERUP_CYC,
  parameter int unsigned DLLK_CYCLES = 512,
  parameter int unsigned ZQINIT_CYCLES = 512,
  parameter int unsigned BURST_CYCLES = 4
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [2:0] BA,
  input wire logic [12:0] ADDR,
  input wire logic ODT,
  output logic ODT_EN,
  output logic INIT_DONE,
  output logic IDLE,
  output logic ACTIVE_PD,
  output logic PRECHARGE_PD,
  output logic SELF_REFRESH,
  output logic REFRESH_RUN,
  output logic SEQ_ERROR,
  output dcp_pkg::dcp_state_e STATE
);
  import dcp_pkg::*;

  typedef struct packed {
    dcp_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] dllk;
    logic [CNT_W-1:0] zq;
    logic [CNT_W-1:0] burst;
    logic [7:0] banks;
    logic cke_q;
    logic odt_en;
    logic err;
  } dcp_s;

  dcp_s r, next_r;
  logic rst_n_s;

  dcp_sync u_rst_sync (
    .CLOCK(CLOCK),
    .RST(RST),
    .din(RESET_N),
    .dout(rst_n_s)
  );

  // Deselect decodes the same as NOP, so neither touches a burst.
  function automatic dcp_cmd_e decode(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    if (cs_n) begin
      return DCP_CMD_NOP;
    end
    unique case ({ras_n, cas_n, we_n})
      3'h7: return DCP_CMD_NOP;
      3'h3: return DCP_CMD_ACT;
      3'h5, 3'h4: return DCP_CMD_RW;
      3'h2: return DCP_CMD_PRE;
      3'h1: return DCP_CMD_REF;
      3'h0: return DCP_CMD_MRS;
      3'h6: return DCP_CMD_ZQL;
      default: return DCP_CMD_OTHER;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
    return (v == '0) ? v : v - CNT_W'(1);
  endfunction

  dcp_cmd_e cmd;
  logic cke_fall;
  logic cke_rise;
  logic timers_done;

  assign cmd = decode(CS_N, RAS_N, CAS_N, WE_N);
  // ODT is not an input of any transition below.
  assign cke_fall = r.cke_q && !CKE;
  assign cke_rise = !r.cke_q && CKE;
  assign timers_done = (r.cnt == '0) && (r.burst == '0);

  always_comb begin
    next_r = r;
    next_r.cke_q = CKE;
    next_r.cnt = dec(r.cnt);
    next_r.dllk = dec(r.dllk);
    next_r.zq = dec(r.zq);
    next_r.burst = dec(r.burst);
    unique case (r.st)
      DCP_RESET: begin
        next_r.odt_en = 1'b0;
        next_r.cnt = CNT_W'(POWERUP_CYCLES);
        next_r.banks = '0;
        if (rst_n_s) begin
          next_r.st = DCP_WAKE;
        end
      end
      DCP_WAKE: begin
        // Internal init runs on its own counter; early CKE is flagged.
        if (CKE) begin
          next_r.err = r.err || (r.cnt != '0);
          next_r.odt_en = 1'b1;
          next_r.cnt = CNT_W'(XPR_CYC);
          next_r.st = DCP_XPR;
        end
      end
      DCP_XPR: begin
        if (cmd == DCP_CMD_MRS) begin
          next_r.err = r.err || (r.cnt != '0) || (BA != BA_MR2);
          next_r.st = DCP_MR2;
        end
      end
      DCP_MR2: begin
        if (cmd == DCP_CMD_MRS) begin
          next_r.err = r.err || (BA != BA_MR3);
          next_r.st = DCP_MR3;
        end
      end
      DCP_MR3: begin
        if (cmd == DCP_CMD_MRS) begin
          next_r.err = r.err || (BA != BA_MR1) || ADDR[A_DLL_EN];
          next_r.st = DCP_MR1;
        end
      end
      DCP_MR1: begin
        if (cmd == DCP_CMD_MRS) begin
          next_r.err = r.err || (BA != BA_MR0) || !ADDR[A_DLL_RST];
          next_r.dllk = CNT_W'(DLLK_CYCLES);
          next_r.st = DCP_MR0;
        end
      end
      DCP_MR0: begin
        if (cmd == DCP_CMD_ZQL && ADDR[A_ZQ_LONG]) begin
          next_r.zq = CNT_W'(ZQINIT_CYCLES);
          next_r.st = DCP_CAL;
        end
      end
      DCP_CAL: begin
        if (r.dllk == '0 && r.zq == '0) begin
          next_r.st = DCP_IDLE;
        end
      end
      DCP_IDLE, DCP_ACTIVE, DCP_BUSY: begin
        if (cke_fall) begin
          if (cmd == DCP_CMD_REF && r.st == DCP_IDLE && timers_done) begin
            next_r.st = DCP_SREF;
            next_r.odt_en = 1'b0;
          end else if (r.banks == '0) begin
            next_r.st = DCP_PPD;
          end else begin
            next_r.st = DCP_APD;
          end
        end else if (CKE) begin
          unique case (cmd)
            DCP_CMD_ACT: next_r.banks[BA] = 1'b1;
            DCP_CMD_PRE: begin
              if (ADDR[A_ZQ_LONG]) begin
                next_r.banks = '0;
              end else begin
                next_r.banks[BA] = 1'b0;
              end
            end
            DCP_CMD_RW: next_r.burst = CNT_W'(BURST_CYCLES);
            DCP_CMD_REF: next_r.cnt = CNT_W'(XS_CYC);
            default: ;
          endcase
          if (next_r.banks != '0) begin
            next_r.st = (next_r.burst != '0) ? DCP_BUSY : DCP_ACTIVE;
          end else begin
            next_r.st = (next_r.burst != '0) ? DCP_BUSY : DCP_IDLE;
          end
        end
      end
      DCP_APD, DCP_PPD: begin
        // Commands are don't-care here; only CKE rising leaves.
        if (cke_rise) begin
          next_r.cnt = CNT_W'(XP_CYC);
          next_r.st = (r.st == DCP_APD) ? DCP_ACTIVE : DCP_IDLE;
        end
      end
      DCP_SREF: begin
        // CKE is sampled directly, not through the command decode.
        if (CKE) begin
          next_r.cnt = CNT_W'(XS_CYC);
          next_r.st = DCP_EXIT;
        end
      end
      DCP_EXIT: begin
        next_r.odt_en = 1'b1;
        if (r.cnt == '0) begin
          next_r.st = DCP_IDLE;
        end
      end
      default: next_r.st = DCP_RESET;
    endcase
    if (!rst_n_s) begin
      next_r.st = DCP_RESET;
      next_r.odt_en = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign STATE = r.st;
  assign ODT_EN = r.odt_en && ODT;
  assign INIT_DONE = (r.st == DCP_IDLE) || (r.st == DCP_ACTIVE) ||
                     (r.st == DCP_BUSY) || (r.st == DCP_APD) ||
                     (r.st == DCP_PPD) || (r.st == DCP_SREF) ||
                     (r.st == DCP_EXIT);
  // Idle needs closed banks, no burst, CKE high and expired timers.
  assign IDLE = (r.st == DCP_IDLE) && r.cke_q && timers_done;
  assign ACTIVE_PD = (r.st == DCP_APD);
  assign PRECHARGE_PD = (r.st == DCP_PPD);
  assign SELF_REFRESH = (r.st == DCP_SREF);
  assign REFRESH_RUN = (r.st == DCP_SREF);
  assign SEQ_ERROR = r.err;
endmodule

// File: logic/dcp_sync.sv
// Three-stage input synchroniser with agreement filter.
module dcp_sync (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } dcp_sync_s;
  dcp_sync_s r, next_r;
  always_comb begin
    next_r = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // Agreement of two settled stages keeps a metastable glitch out.
    if (r.s2 == r.s3) begin
      next_r.q = r.s3;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign dout = r.q;
endmodule

// File: tb/dcp_ctl_model.sv
// Memory controller model driving reset, clock enable, ODT and commands.
module dcp_ctl_model (
  input wire logic CLOCK,
  output logic RESET_N,
  output logic CKE,
  output logic CS_N,
  output logic RAS_N,
  output logic CAS_N,
  output logic WE_N,
  output logic [2:0] BA,
  output logic [12:0] ADDR,
  output logic ODT
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    RESET_N = 1'b0;
    CKE = 1'b0;
    ODT = 1'b0;
    {CS_N, RAS_N, CAS_N, WE_N} = 4'hF;
    BA = 3'h0;
    ADDR = 13'h0000;
  end
  // Pulls the reset pin mid-run; CKE goes low with it.
  task automatic hold_reset;
    @(posedge CLOCK);
    #1;
    CKE = 1'b0;
    RESET_N = 1'b0;
  endtask
  task automatic rel_reset;
    @(posedge CLOCK);
    #1;
    RESET_N = 1'b1;
  endtask
  // One command a clock; a deselected bus toggles so stale values never pass.
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
      input logic [12:0] a, input logic k, input logic o);
    @(posedge CLOCK);
    #1;
    CKE = k;
    ODT = o;
    {CS_N, RAS_N, CAS_N, WE_N} = c[3] ? {1'b1, ~RAS_N, ~CAS_N, ~WE_N} : c;
    BA = c[3] ? ~BA : b;
    ADDR = c[3] ? ~ADDR : a;
  endtask
  // Waits are whole-cycle NOP runs; CKE only moves with NOP here.
  task automatic nops(input int n, input logic k, input logic o);
    repeat (n) begin
      cmd(4'h7, 3'h0, 13'h0000, k, o);
    end
  endtask
endmodule

// File: tb/dcp_power_state_checker.sv
// Checker with concurrent assertions on the power-state block ports.
module dcp_power_state_checker
  import dcp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic ODT_EN,
  input wire logic IDLE,
  input wire logic ACTIVE_PD,
  input wire logic PRECHARGE_PD,
  input wire logic SELF_REFRESH,
  input wire logic REFRESH_RUN,
  input wire dcp_pkg::dcp_state_e STATE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  wire nop = CS_N | (RAS_N & CAS_N & WE_N);
  wire refc = !CS_N & !RAS_N & !CAS_N & WE_N;
  wire pd = ACTIVE_PD | PRECHARGE_PD;
  odt_hiz_a: assert property (
    STATE inside {DCP_RESET, DCP_WAKE} |-> !ODT_EN)
    else $error("termination enabled before clock enable rose");
  sref_odt_a: assert property (
    SELF_REFRESH |-> !ODT_EN)
    else $error("termination enabled in self-refresh");
  pd_norefresh_a: assert property (
    pd |-> !REFRESH_RUN)
    else $error("refresh running in power-down");
  ppd_entry_a: assert property (
    STATE == DCP_IDLE && $fell(CKE) && nop |=> PRECHARGE_PD)
    else $error("idle with clock enable low did not power down");
  apd_entry_a: assert property (
    STATE == DCP_ACTIVE && $fell(CKE) && nop |=> ACTIVE_PD)
    else $error("open bank did not enter active power-down");
  busy_pd_a: assert property (
    STATE == DCP_BUSY && $fell(CKE) && nop |=> pd)
    else $error("burst with clock enable low did not power down");
  sref_entry_a: assert property (
    IDLE && $fell(CKE) && refc |=> SELF_REFRESH)
    else $error("refresh with clock enable low missed self-refresh");
  sref_exit_a: assert property (
    SELF_REFRESH && CKE |=> !SELF_REFRESH)
    else $error("self-refresh did not exit on clock enable");
  pd_hold_a: assert property (
    pd && !CKE |=> !IDLE && !SELF_REFRESH)
    else $error("command acted on in power-down");
  cover property (PRECHARGE_PD);
  cover property (ACTIVE_PD);
  cover property (SELF_REFRESH);
endmodule
bind dcp_power_state dcp_power_state_checker dcp_power_state_checker_i (
  .CLOCK(CLOCK), .RST(RST), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
  .CAS_N(CAS_N), .WE_N(WE_N), .ODT_EN(ODT_EN), .IDLE(IDLE),
  .ACTIVE_PD(ACTIVE_PD), .PRECHARGE_PD(PRECHARGE_PD),
  .SELF_REFRESH(SELF_REFRESH), .REFRESH_RUN(REFRESH_RUN), .STATE(STATE));

// File: tb/tb.sv
// Self-checking testbench for the DDR3 power-state block.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dcp_pkg::*;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic RESET_N, CKE, CS_N, RAS_N, CAS_N, WE_N, ODT;
  logic [2:0] BA;
  logic [12:0] ADDR;
  logic ODT_EN, INIT_DONE, IDLE, ACTIVE_PD, PRECHARGE_PD;
  logic SELF_REFRESH, REFRESH_RUN, SEQ_ERROR;
  dcp_state_e STATE;
  int n_errors = 0;
  int num_checks = 0;
  always #25 CLOCK = ~CLOCK;
  dcp_ctl_model dcp_ctl_model_i (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N),
    .BA(BA), .ADDR(ADDR), .ODT(ODT));
  dcp_power_state #(.POWERUP_CYCLES(20), .DLLK_CYCLES(8),
    .ZQINIT_CYCLES(8)) dcp_power_state_i (.CLOCK(CLOCK), .RST(RST),
    .RESET_N(RESET_N), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
    .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .ADDR(ADDR), .ODT(ODT),
    .ODT_EN(ODT_EN), .INIT_DONE(INIT_DONE), .IDLE(IDLE),
    .ACTIVE_PD(ACTIVE_PD), .PRECHARGE_PD(PRECHARGE_PD),
    .SELF_REFRESH(SELF_REFRESH), .REFRESH_RUN(REFRESH_RUN),
    .SEQ_ERROR(SEQ_ERROR), .STATE(STATE));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_init;
    logic [2:0] bs [4] = '{BA_MR2, BA_MR3, BA_MR1, BA_MR0};
    logic [12:0] as [4] = '{13'h0000, 13'h0000, 13'h0000, 13'h0100};
    dcp_ctl_model_i.nops(4000, 1'b0, 1'b1);
    chk(ODT_EN, 1'b0);
    dcp_ctl_model_i.rel_reset();
    dcp_ctl_model_i.nops(40, 1'b0, 1'b1);
    chk(ODT_EN, 1'b0);
    chk(STATE, DCP_WAKE);
    dcp_ctl_model_i.nops(1, 1'b0, 1'b0);
    dcp_ctl_model_i.nops(7, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      dcp_ctl_model_i.cmd(4'h0, bs[i], as[i], 1'b1, 1'b0);
      dcp_ctl_model_i.nops(3, 1'b1, 1'b0);
    end
    dcp_ctl_model_i.cmd(4'h6, 3'h0, 13'h0400, 1'b1, 1'b0);
    dcp_ctl_model_i.nops(5, 1'b1, 1'b0);
    chk(INIT_DONE, 1'b0);
    dcp_ctl_model_i.nops(8, 1'b1, 1'b0);
    chk({INIT_DONE, IDLE, SEQ_ERROR}, 3'h6);
    chk(STATE, DCP_IDLE);
    $display("init test done");
  endtask
  task automatic t_ppd;
    dcp_ctl_model_i.nops(1, 1'b0, 1'b1);
    dcp_ctl_model_i.cmd(4'h1, 3'h0, 13'h0000, 1'b0, 1'b1);
    dcp_ctl_model_i.cmd(4'h3, 3'h1, 13'h0000, 1'b0, 1'b1);
    chk({PRECHARGE_PD, ACTIVE_PD, SELF_REFRESH}, 3'h4);
    chk(REFRESH_RUN, 1'b0);
    dcp_ctl_model_i.nops(1, 1'b1, 1'b0);
    dcp_ctl_model_i.nops(4, 1'b1, 1'b0);
    chk(IDLE, 1'b1);
    $display("precharge power-down test done");
  endtask
  task automatic t_apd;
    dcp_ctl_model_i.cmd(4'h3, 3'h0, 13'h0000, 1'b1, 1'b0);
    dcp_ctl_model_i.nops(1, 1'b1, 1'b0);
    dcp_ctl_model_i.cmd(4'h5, 3'h0, 13'h0000, 1'b1, 1'b0);
    dcp_ctl_model_i.nops(3, 1'b0, 1'b0);
    chk(ACTIVE_PD, 1'b1);
    dcp_ctl_model_i.nops(5, 1'b1, 1'b0);
    chk(STATE, DCP_ACTIVE);
    dcp_ctl_model_i.nops(3, 1'b0, 1'b0);
    chk({ACTIVE_PD, PRECHARGE_PD}, 2'h2);
    dcp_ctl_model_i.nops(4, 1'b1, 1'b0);
    dcp_ctl_model_i.cmd(4'h2, 3'h0, 13'h0400, 1'b1, 1'b0);
    dcp_ctl_model_i.nops(8, 1'b1, 1'b0);
    chk(IDLE, 1'b1);
    $display("active power-down test done");
  endtask
  task automatic t_sref;
    dcp_ctl_model_i.cmd(4'h1, 3'h0, 13'h0000, 1'b0, 1'b1);
    dcp_ctl_model_i.cmd(4'h8, 3'h0, 13'h0000, 1'b0, 1'b1);
    chk({SELF_REFRESH, ODT_EN}, 2'h2);
    chk(REFRESH_RUN, 1'b1);
    dcp_ctl_model_i.cmd(4'h8, 3'h0, 13'h0000, 1'b1, 1'b0);
    dcp_ctl_model_i.cmd(4'h8, 3'h0, 13'h0000, 1'b1, 1'b0);
    chk(SELF_REFRESH, 1'b0);
    dcp_ctl_model_i.nops(8, 1'b1, 1'b0);
    chk(IDLE, 1'b1);
    $display("self-refresh test done");
  endtask
  task automatic t_early;
    dcp_ctl_model_i.hold_reset();
    dcp_ctl_model_i.nops(6, 1'b0, 1'b1);
    chk(STATE, DCP_RESET);
    chk(ODT_EN, 1'b0);
    dcp_ctl_model_i.rel_reset();
    dcp_ctl_model_i.nops(6, 1'b0, 1'b0);
    chk(STATE, DCP_WAKE);
    dcp_ctl_model_i.nops(2, 1'b1, 1'b0);
    chk({STATE, SEQ_ERROR}, {DCP_XPR, 1'b1});
    $display("early clock enable test done");
  endtask
  initial begin
    repeat (5) @(posedge CLOCK);
    #1;
    RST = 1'b0;
    t_init();
    t_ppd();
    t_apd();
    t_sref();
    t_early();
    test_done();
  end
  // The tests take about 4200 cycles; allow well over that.
  initial begin
    #(8000 * 50);
    n_errors++;
    test_done();
  end
endmodule
